// file: pkg/sdrc_pkg.sv
// constants and types for the card-side read command decoder
package sdrc_pkg;
  // command indices
  localparam logic [5:0] CMD_STOP = 6'h0c;
  localparam logic [5:0] CMD_STATUS = 6'h0d;
  localparam logic [5:0] CMD_RSV_A = 6'h0e;
  localparam logic [5:0] CMD_INACT = 6'h0f;
  localparam logic [5:0] CMD_BLKLEN = 6'h10;
  localparam logic [5:0] CMD_RD_ONE = 6'h11;
  localparam logic [5:0] CMD_RD_MULTI = 6'h12;
  localparam logic [5:0] CMD_TUNE = 6'h13;
  localparam logic [5:0] CMD_SPEED = 6'h14;
  localparam logic [5:0] CMD_RSV_B = 6'h16;
  localparam logic [5:0] CMD_BLKCNT = 6'h17;
  // wishbone register byte offsets
  localparam logic [7:0] WB_CTRL = 8'h00;
  localparam logic [7:0] WB_TASK = 8'h04;
  localparam logic [7:0] WB_STATUS = 8'h08;
  localparam logic [7:0] WB_BLKLEN = 8'h0c;
  localparam logic [7:0] WB_BLKCNT = 8'h10;
  localparam logic [7:0] WB_SPEED = 8'h14;
  localparam logic [7:0] WB_STATE = 8'h18;
  // control register fields
  localparam int CTRL_CCS = 0;
  localparam int CTRL_CQ = 1;
  localparam int CTRL_PARTIAL = 2;
  localparam int CTRL_MISALIGN = 3;
  localparam int RCA_LSB = 16;
  localparam int RCA_W = 16;
  localparam int ARG_TASK_SEL = 15;
  // card status fields
  localparam int ST_ADDR_ERR = 30;
  localparam int ST_LEN_ERR = 29;
  localparam int ST_ILLEGAL = 22;
  localparam int ST_STATE_LSB = 9;
  localparam int ST_READY = 8;
  localparam logic [3:0] CS_TRAN = 4'h4;
  localparam logic [3:0] CS_DATA = 4'h5;
  // pending error flag indices
  localparam int E_ADDR = 0;
  localparam int E_LEN = 1;
  localparam int E_ILL = 2;
  // block sizes
  localparam logic [31:0] BLK_DEF = 32'h0000_0200;
  localparam logic [9:0] TUNE_LEN = 10'h040;
  localparam int BLK_SHIFT = 9;
  // frame and timing, counted in link clock edges
  localparam logic [5:0] FRAME_LAST = 6'h2f;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] CRC_LAST = 4'hf;
  localparam logic [2:0] NCR_EDGES = 3'h2;
  localparam logic [3:0] NAC_EDGES = 4'h2;
  localparam logic [3:0] BUSY_EDGES = 4'h8;
  localparam logic [6:0] CRC7_POLY = 7'h09;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  typedef enum logic [2:0] {DS_IDLE, DS_WAIT, DS_DATA, DS_CRC, DS_END, DS_BUSY} sdrc_dst_t;
endpackage

// file: hw/sdrc_card.sv
// card-side decoder and executor for status, inactive, block length and read commands
// How it works
// - no queuing: status query returns card status
// - queuing, bit 15 low: card status
// - queuing, bit 15 high: task status
// - deactivate with own address: inactive, silent
// - standard card: block length from argument
// - block length defaults to 512 bytes
// - programmed length used only if partial allowed
// - high capacity reads always 512 bytes
// - length above 512 sets length error
// - single read: response then one block
// - multi read streams blocks until stop, or until a preset block count runs out
// - tuning command sends 64-byte pattern
// - speed class: function, parameter, busy answer
// - block count stored, taken and cleared by the next accepted read command of any kind
// - first block may not cross the boundary unless misalign allowed
// - addresses bytes or 512-byte blocks by capacity
// - stop ends multi read, busy answer
`timescale 1ns/100ps
module sdrc_card (
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // card link
  input wire logic sclk_i,
  input wire logic cmd_i,
  output logic cmd_o,
  output logic cmd_oe_n_o,
  output logic dat_o,
  output logic dat_oe_n_o,
  // memory read port
  output logic [31:0] mem_addr_o,
  input wire logic [7:0] mem_data_i
);
  typedef struct packed {
    logic [2:0] ck_s;
    logic [2:0] cmd_s;
    logic ck_lvl;
    logic rx_on;
    logic [5:0] rx_cnt;
    logic [47:0] rx_sh;
    logic tx_on;
    logic [2:0] tx_wait;
    logic [5:0] tx_cnt;
    logic [47:0] tx_sh;
    logic cmd_o;
    logic cmd_oe_n;
    sdrc_pkg::sdrc_dst_t dst;
    logic [3:0] wcnt;
    logic [9:0] dcnt;
    logic [3:0] bit_cnt;
    logic [7:0] dbyte;
    logic [15:0] crc;
    logic [31:0] addr;
    logic multi;
    logic tune;
    logic [9:0] len;
    logic [31:0] blk_left;
    logic dat_o;
    logic dat_oe_n;
    logic inactive;
    logic [31:0] blklen;
    logic [31:0] blkcnt;
    logic [31:0] speed;
    logic [2:0] err;
    logic [31:0] ctrl;
    logic [31:0] task_st;
    logic ack;
    logic [31:0] rdat;
  } sdrc_state_t;

  sdrc_state_t q;
  sdrc_state_t n;
  logic [1:0] rst_ff;
  logic rst_n;
  logic rise;
  logic fall;
  logic [47:0] frame;
  logic frame_ok;
  logic [5:0] cmd_idx;
  logic [31:0] cmd_arg;
  logic rca_hit;

  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = '0;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? sdrc_pkg::CRC7_POLY : 7'h00);
    end
    return c;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] status_word(input logic [2:0] e, input logic busy);
    logic [31:0] w;
    w = '0;
    w[sdrc_pkg::ST_ADDR_ERR] = e[sdrc_pkg::E_ADDR];
    w[sdrc_pkg::ST_LEN_ERR] = e[sdrc_pkg::E_LEN];
    w[sdrc_pkg::ST_ILLEGAL] = e[sdrc_pkg::E_ILL];
    w[sdrc_pkg::ST_STATE_LSB +: 4] = busy ? sdrc_pkg::CS_DATA : sdrc_pkg::CS_TRAN;
    w[sdrc_pkg::ST_READY] = ~busy;
    return w;
  endfunction

  function automatic logic [47:0] resp(input logic [5:0] idx, input logic [31:0] w);
    return {2'b00, idx, w, crc7({2'b00, idx, w}), 1'b1};
  endfunction

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_ff[1];

  // a link edge counts once the second and third sampling stages agree
  assign rise = (q.ck_s[1] == q.ck_s[2]) && q.ck_s[2] && !q.ck_lvl;
  assign fall = (q.ck_s[1] == q.ck_s[2]) && !q.ck_s[2] && q.ck_lvl;
  assign frame = {q.rx_sh[46:0], q.cmd_s[2]};
  assign cmd_idx = frame[45:40];
  assign cmd_arg = frame[39:8];
  assign frame_ok = rise && q.rx_on && (q.rx_cnt == sdrc_pkg::FRAME_LAST) && frame[46] && frame[0] && !q.inactive;
  assign rca_hit = cmd_arg[sdrc_pkg::RCA_LSB +: sdrc_pkg::RCA_W] == q.ctrl[sdrc_pkg::RCA_LSB +: sdrc_pkg::RCA_W];

  always_comb begin
    logic [9:0] eff_len;
    logic [31:0] start;
    logic [10:0] span;
    logic [2:0] eset;
    logic [7:0] next_byte;
    logic busy;
    logic wb_req;
    eff_len = '0;
    start = '0;
    span = '0;
    eset = '0;
    wb_req = 1'b0;
    n = q;
    busy = (q.dst != sdrc_pkg::DS_IDLE) && (q.dst != sdrc_pkg::DS_BUSY);
    next_byte = q.tune ? q.addr[7:0] : mem_data_i;
    n.ck_s = {q.ck_s[1:0], sclk_i};
    n.cmd_s = {q.cmd_s[1:0], cmd_i};
    if (rise) n.ck_lvl = 1'b1;
    if (fall) n.ck_lvl = 1'b0;

    // command receiver; own response is not taken as a command
    if (rise && !q.tx_on) begin
      if (!q.rx_on) begin
        if (!q.cmd_s[2]) begin
          n.rx_on = 1'b1;
          n.rx_cnt = 6'h01;
          n.rx_sh = '0;
        end
      end else begin
        n.rx_sh = frame;
        n.rx_cnt = q.rx_cnt + 6'h01;
        if (q.rx_cnt == sdrc_pkg::FRAME_LAST) n.rx_on = 1'b0;
      end
    end

    // response sender, changes on falling link edges
    if (fall) begin
      if (q.tx_on) begin
        if (q.tx_wait != 3'h0) begin
          n.tx_wait = q.tx_wait - 3'h1;
        end else begin
          n.cmd_o = q.tx_sh[47];
          n.cmd_oe_n = 1'b0;
          n.tx_sh = {q.tx_sh[46:0], 1'b1};
          n.tx_cnt = q.tx_cnt + 6'h01;
          if (q.tx_cnt == sdrc_pkg::FRAME_LAST) n.tx_on = 1'b0;
        end
      end else begin
        n.cmd_o = 1'b1;
        n.cmd_oe_n = 1'b1;
      end
    end

    // data sender
    if (fall) begin
      unique case (q.dst)
        sdrc_pkg::DS_IDLE: begin
          n.dat_o = 1'b1;
          n.dat_oe_n = 1'b1;
        end
        sdrc_pkg::DS_WAIT: begin
          if (q.wcnt != 4'h0) begin
            n.wcnt = q.wcnt - 4'h1;
          end else begin
            n.dat_o = 1'b0;
            n.dat_oe_n = 1'b0;
            n.dbyte = next_byte;
            n.addr = q.addr + 32'h1;
            n.dcnt = '0;
            n.bit_cnt = '0;
            n.crc = '0;
            n.dst = sdrc_pkg::DS_DATA;
          end
        end
        sdrc_pkg::DS_DATA: begin
          n.dat_o = q.dbyte[7];
          n.crc = {q.crc[14:0], 1'b0} ^ ((q.crc[15] ^ q.dbyte[7]) ? sdrc_pkg::CRC16_POLY : 16'h0000);
          n.dbyte = {q.dbyte[6:0], 1'b0};
          n.bit_cnt = q.bit_cnt + 4'h1;
          if (q.bit_cnt == sdrc_pkg::BIT_LAST) begin
            n.bit_cnt = '0;
            if (q.dcnt == q.len - 10'h001) begin
              n.dst = sdrc_pkg::DS_CRC;
            end else begin
              n.dcnt = q.dcnt + 10'h001;
              n.dbyte = next_byte;
              n.addr = q.addr + 32'h1;
            end
          end
        end
        sdrc_pkg::DS_CRC: begin
          n.dat_o = q.crc[15];
          n.crc = {q.crc[14:0], 1'b0};
          n.bit_cnt = q.bit_cnt + 4'h1;
          if (q.bit_cnt == sdrc_pkg::CRC_LAST) n.dst = sdrc_pkg::DS_END;
        end
        sdrc_pkg::DS_END: begin
          n.dat_o = 1'b1;
          n.dst = sdrc_pkg::DS_IDLE;
          // a preset count of zero means stream until stopped
          if (q.multi && q.blk_left != 32'h1) begin
            if (q.blk_left != 32'h0) n.blk_left = q.blk_left - 32'h1;
            n.dst = sdrc_pkg::DS_WAIT;
            n.wcnt = sdrc_pkg::NAC_EDGES;
          end else begin
            n.multi = 1'b0;
          end
        end
        sdrc_pkg::DS_BUSY: begin
          n.dat_o = 1'b0;
          n.dat_oe_n = 1'b0;
          if (q.wcnt == 4'h0) n.dst = sdrc_pkg::DS_IDLE;
          else n.wcnt = q.wcnt - 4'h1;
        end
      endcase
    end

    // command execution
    if (frame_ok) begin
      if (q.ctrl[sdrc_pkg::CTRL_CCS]) begin
        eff_len = sdrc_pkg::BLK_DEF[9:0];
        start = cmd_arg << sdrc_pkg::BLK_SHIFT;
      end else begin
        eff_len = q.ctrl[sdrc_pkg::CTRL_PARTIAL] ? q.blklen[9:0] : sdrc_pkg::BLK_DEF[9:0];
        start = cmd_arg;
      end
      span = {2'b00, start[8:0]} + {1'b0, eff_len};
      n.tx_wait = sdrc_pkg::NCR_EDGES;
      n.tx_cnt = '0;
      unique case (cmd_idx)
        sdrc_pkg::CMD_STATUS: begin
          if (rca_hit) begin
            n.tx_on = 1'b1;
            n.err = '0;
            if (q.ctrl[sdrc_pkg::CTRL_CQ] && cmd_arg[sdrc_pkg::ARG_TASK_SEL]) begin
              n.tx_sh = resp(cmd_idx, q.task_st);
            end else begin
              n.tx_sh = resp(cmd_idx, status_word(q.err, busy));
            end
          end
        end
        sdrc_pkg::CMD_INACT: begin
          if (rca_hit) begin
            n.inactive = 1'b1;
            n.dst = sdrc_pkg::DS_IDLE;
            n.multi = 1'b0;
          end
        end
        sdrc_pkg::CMD_BLKLEN: begin
          // zero is refused as well, its block would run 1024 bytes
          if (cmd_arg > sdrc_pkg::BLK_DEF || cmd_arg == 32'h0) eset[sdrc_pkg::E_LEN] = 1'b1;
          else n.blklen = cmd_arg;
        end
        sdrc_pkg::CMD_RD_ONE, sdrc_pkg::CMD_RD_MULTI, sdrc_pkg::CMD_TUNE: begin
          if (cmd_idx != sdrc_pkg::CMD_TUNE && !q.ctrl[sdrc_pkg::CTRL_MISALIGN] && span > sdrc_pkg::BLK_DEF[10:0]) begin
            eset[sdrc_pkg::E_ADDR] = 1'b1;
          end else if (q.dst == sdrc_pkg::DS_IDLE) begin
            n.dst = sdrc_pkg::DS_WAIT;
            n.wcnt = sdrc_pkg::NAC_EDGES;
            n.tune = cmd_idx == sdrc_pkg::CMD_TUNE;
            n.multi = cmd_idx == sdrc_pkg::CMD_RD_MULTI;
            n.len = n.tune ? sdrc_pkg::TUNE_LEN : eff_len;
            n.addr = n.tune ? 32'h0 : start;
            n.blk_left = q.blkcnt;
            n.blkcnt = '0;
          end
        end
        sdrc_pkg::CMD_SPEED: begin
          n.speed = cmd_arg;
          if (q.dst == sdrc_pkg::DS_IDLE) begin
            n.dst = sdrc_pkg::DS_BUSY;
            n.wcnt = sdrc_pkg::BUSY_EDGES;
          end
        end
        sdrc_pkg::CMD_BLKCNT: n.blkcnt = cmd_arg;
        sdrc_pkg::CMD_STOP: begin
          if (q.multi) begin
            n.multi = 1'b0;
            n.dst = sdrc_pkg::DS_BUSY;
            n.wcnt = sdrc_pkg::BUSY_EDGES;
          end
        end
        sdrc_pkg::CMD_RSV_A, sdrc_pkg::CMD_RSV_B: eset[sdrc_pkg::E_ILL] = 1'b1;
        default: ;
      endcase
      if (cmd_idx inside {sdrc_pkg::CMD_BLKLEN, sdrc_pkg::CMD_RD_ONE, sdrc_pkg::CMD_RD_MULTI, sdrc_pkg::CMD_TUNE,
                          sdrc_pkg::CMD_SPEED, sdrc_pkg::CMD_BLKCNT, sdrc_pkg::CMD_STOP}) begin
        // errors of this command are reported in its own answer, then cleared
        n.tx_on = 1'b1;
        n.tx_sh = resp(cmd_idx, status_word(q.err | eset, busy));
        n.err = '0;
      end else if (!n.tx_on) begin
        // an answered status query has cleared the pending errors, reporting them only in a card status answer
        n.err = q.err | eset;
      end
    end

    // wishbone slave, one wait state
    wb_req = wb_cyc_i && wb_stb_i && !q.ack;
    n.ack = wb_req;
    if (wb_req) begin
      unique case (wb_adr_i)
        sdrc_pkg::WB_CTRL: n.rdat = q.ctrl;
        sdrc_pkg::WB_TASK: n.rdat = q.task_st;
        sdrc_pkg::WB_STATUS: n.rdat = status_word(q.err, busy);
        sdrc_pkg::WB_BLKLEN: n.rdat = q.blklen;
        sdrc_pkg::WB_BLKCNT: n.rdat = q.blkcnt;
        sdrc_pkg::WB_SPEED: n.rdat = q.speed;
        sdrc_pkg::WB_STATE: n.rdat = {29'h0, q.multi, busy, q.inactive};
        default: n.rdat = '0;
      endcase
      if (wb_we_i && wb_adr_i == sdrc_pkg::WB_CTRL) n.ctrl = merge(q.ctrl, wb_dat_i, wb_sel_i);
      if (wb_we_i && wb_adr_i == sdrc_pkg::WB_TASK) n.task_st = merge(q.task_st, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.cmd_o <= 1'b1;
      q.cmd_oe_n <= 1'b1;
      q.dat_o <= 1'b1;
      q.dat_oe_n <= 1'b1;
      q.dst <= sdrc_pkg::DS_IDLE;
      q.blklen <= sdrc_pkg::BLK_DEF;
    end else begin
      q <= n;
    end
  end

  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign cmd_o = q.cmd_o;
  assign cmd_oe_n_o = q.cmd_oe_n;
  assign dat_o = q.dat_o;
  assign dat_oe_n_o = q.dat_oe_n;
  assign mem_addr_o = q.addr;

  AST_LEN_ERR: assert property (@(posedge mclk_i) disable iff (!rst_n)
    frame_ok && cmd_idx == sdrc_pkg::CMD_BLKLEN && cmd_arg > sdrc_pkg::BLK_DEF
    |=> q.tx_sh[sdrc_pkg::ST_LEN_ERR + 8] && q.blklen == $past(q.blklen))
    else $error("oversized block length not flagged");
  AST_LEN_SET: assert property (@(posedge mclk_i) disable iff (!rst_n)
    frame_ok && cmd_idx == sdrc_pkg::CMD_BLKLEN && cmd_arg <= sdrc_pkg::BLK_DEF && cmd_arg != 32'h0
    |=> q.blklen == $past(cmd_arg))
    else $error("block length not stored");
  AST_INACT: assert property (@(posedge mclk_i) disable iff (!rst_n)
    frame_ok && cmd_idx == sdrc_pkg::CMD_INACT && rca_hit |=> q.inactive && !q.tx_on)
    else $error("deactivate did not silence card");
  AST_INACT_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n)
    q.inactive |=> q.inactive && !q.tx_on && q.dst == sdrc_pkg::DS_IDLE)
    else $error("inactive card became active");
  AST_ILLEGAL: assert property (@(posedge mclk_i) disable iff (!rst_n)
    frame_ok && (cmd_idx == sdrc_pkg::CMD_RSV_A || cmd_idx == sdrc_pkg::CMD_RSV_B)
    |=> q.err[sdrc_pkg::E_ILL] && !q.tx_on)
    else $error("reserved index not treated as illegal");
  AST_TASK: assert property (@(posedge mclk_i) disable iff (!rst_n)
    frame_ok && cmd_idx == sdrc_pkg::CMD_STATUS && rca_hit && q.ctrl[sdrc_pkg::CTRL_CQ]
    && cmd_arg[sdrc_pkg::ARG_TASK_SEL] |=> q.tx_on && q.tx_sh[39:8] == $past(q.task_st))
    else $error("task status not returned");
  AST_STOP: assert property (@(posedge mclk_i) disable iff (!rst_n)
    frame_ok && cmd_idx == sdrc_pkg::CMD_STOP && q.multi |=> q.dst == sdrc_pkg::DS_BUSY && !q.multi && q.tx_on)
    else $error("stop did not end the stream");
  AST_BLKCNT: assert property (@(posedge mclk_i) disable iff (!rst_n)
    frame_ok && cmd_idx == sdrc_pkg::CMD_BLKCNT |=> q.blkcnt == $past(cmd_arg))
    else $error("block count not stored");
  AST_BLOCK_LEN: assert property (@(posedge mclk_i) disable iff (!rst_n)
    q.dst == sdrc_pkg::DS_DATA |-> q.dcnt < q.len && (q.tune || q.len <= sdrc_pkg::BLK_DEF[9:0]))
    else $error("data block overran its length");
endmodule

// file: test/sdrc_host_model.sv
// host controller model: runs the link clock per frame and records card answers
`timescale 1ns/100ps
module sdrc_host_model (
  // link
  output logic sclk_o,
  output logic cmd_o,
  // card side
  input wire logic card_cmd_i,
  input wire logic card_cmd_oe_n_i,
  input wire logic card_dat_i,
  input wire logic card_dat_oe_n_i
);
  logic host_cmd = 1'b1;
  logic [47:0] resp;
  logic [7:0] fb;
  int rcnt;
  int lowcnt;
  int nblk;
  int fbit;
  int blen;
  // pull-up on the wire: the host idles it high, the card takes it while enabled
  assign cmd_o = card_cmd_oe_n_i ? host_cmd : card_cmd_i;
  initial sclk_o = 1'b0;
  // card bits change on falls, so rises see them settled
  always @(posedge sclk_o) begin
    if (!card_cmd_oe_n_i) begin
      resp = {resp[46:0], card_cmd_i};
      rcnt++;
    end
    if (!card_dat_oe_n_i) begin
      if (!card_dat_i) lowcnt++;
      if (fbit > 0 || !card_dat_i) fbit++;
      if (nblk == 0 && fbit >= 2 && fbit <= 9) fb = {fb[6:0], card_dat_i};
      if (fbit == 8 * blen + 18) begin
        nblk++;
        fbit = 0;
      end
    end
  end
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? sdrc_pkg::CRC7_POLY : 7'h00);
    return c;
  endfunction
  // the clock stands still low between frames; extra cycles let the card answer
  task automatic run(input logic [5:0] idx, input logic [31:0] arg, input int extra, input int len);
    logic [47:0] f;
    f = {2'b01, idx, arg, crc7({2'b01, idx, arg}), 1'b1};
    rcnt = 0;
    lowcnt = 0;
    nblk = 0;
    fbit = 0;
    blen = len;
    for (int i = 47; i >= -extra; i--) begin
      #80 sclk_o = 1'b0;
      host_cmd = (i >= 0) ? f[i] : 1'b1;
      #80 sclk_o = 1'b1;
    end
    #80 sclk_o = 1'b0;
  endtask
endmodule

// file: test/tb.sv
// self-checking bench for the card-side read command decoder
`timescale 1ns/100ps
module tb;
  localparam logic [15:0] RCA = 16'h1234;
  logic mclk_i;
  logic arst_n_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic sclk;
  logic cmd_w;
  logic card_cmd;
  logic card_cmd_oe_n;
  logic dat;
  logic dat_oe_n;
  logic [31:0] mem_addr_o;
  logic [7:0] mem_data_i;
  logic [31:0] seed = 32'h608c;
  logic [31:0] q;
  logic [31:0] tw;
  logic [31:0] len;
  logic [31:0] adr;
  logic [47:0] resp;
  logic [7:0] fb;
  int rcnt;
  int lowcnt;
  int nblk;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  // each byte mixes both address bytes so a wrong unit or offset shows up
  assign mem_data_i = mem_addr_o[7:0] ^ mem_addr_o[15:8];
  sdrc_card sdrc_card_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sclk_i(sclk), .cmd_i(cmd_w), .cmd_o(card_cmd), .cmd_oe_n_o(card_cmd_oe_n),
    .dat_o(dat), .dat_oe_n_o(dat_oe_n), .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i));
  sdrc_host_model sdrc_host_model_i (.sclk_o(sclk), .cmd_o(cmd_w), .card_cmd_i(card_cmd),
    .card_cmd_oe_n_i(card_cmd_oe_n), .card_dat_i(dat), .card_dat_oe_n_i(dat_oe_n));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    // only the cycle ceiling ends a wait; the slave answers one cycle after taking
    chk("wishbone ack latency", 32'h2, n);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic ctl(input logic [3:0] b);
    wb(1'b1, sdrc_pkg::WB_CTRL, {RCA, 12'h000, b});
  endtask
  task automatic cmd(input logic [5:0] idx, input logic [31:0] a, input int extra);
    sdrc_host_model_i.run(idx, a, extra, len);
    resp = sdrc_host_model_i.resp;
    rcnt = sdrc_host_model_i.rcnt;
    lowcnt = sdrc_host_model_i.lowcnt;
    nblk = sdrc_host_model_i.nblk;
    fb = sdrc_host_model_i.fb;
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 98000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    arst_n_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    len = 32'h200;
    repeat (5) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    wb(1'b0, sdrc_pkg::WB_BLKLEN, 32'h0);
    chk("blklen reset", 32'h200, q);
    tw = rnd();
    wb(1'b1, sdrc_pkg::WB_TASK, tw);
    for (int m = 0; m < 4; m++) begin
      ctl({2'b01, m[0], 1'b0});
      cmd(sdrc_pkg::CMD_STATUS, {RCA, m[1], 15'h0000}, 60);
      chk("status index", sdrc_pkg::CMD_STATUS, resp[45:40]);
      chk("status crc", sdrc_host_model_i.crc7(resp[47:8]), resp[7:1]);
      if (m == 3) chk("task word", tw, resp[39:8]);
      else chk("status state", sdrc_pkg::CS_TRAN, resp[20:17]);
    end
    cmd(sdrc_pkg::CMD_STATUS, {~RCA, 16'h0000}, 60);
    chk("foreign status", 32'h0, rcnt);
    done("status");
    len = 8 * (1 + rnd() % 4);
    cmd(sdrc_pkg::CMD_BLKLEN, len, 60);
    wb(1'b0, sdrc_pkg::WB_BLKLEN, 32'h0);
    chk("blklen set", len, q);
    cmd(sdrc_pkg::CMD_BLKLEN, 32'd513, 60);
    chk("length error", 32'h1, resp[37]);
    cmd(sdrc_pkg::CMD_STATUS, {RCA, 16'h0000}, 60);
    chk("length error cleared", 32'h0, resp[37]);
    wb(1'b0, sdrc_pkg::WB_BLKLEN, 32'h0);
    chk("blklen kept", len, q);
    done("block length");
    adr = (rnd() & 32'h0000_fe00) | 32'h10;
    cmd(sdrc_pkg::CMD_RD_ONE, adr, 8 * len + 90);
    chk("single blocks", 32'h1, nblk);
    chk("single first byte", adr[7:0] ^ adr[15:8], fb);
    // an offset that makes the block run past the boundary
    adr = 32'h200 - (len >> 1);
    cmd(sdrc_pkg::CMD_RD_ONE, adr, 8 * len + 90);
    chk("misalign error", 32'h1, resp[38]);
    chk("misalign blocks", 32'h0, nblk);
    ctl(4'b1100);
    cmd(sdrc_pkg::CMD_RD_ONE, adr, 8 * len + 90);
    chk("misalign allowed", 32'h1, nblk);
    ctl(4'b0000);
    cmd(sdrc_pkg::CMD_RD_ONE, 32'h10, 8 * len + 90);
    chk("no partial error", 32'h1, resp[38]);
    chk("no partial blocks", 32'h0, nblk);
    done("single read");
    ctl(4'b0100);
    cmd(sdrc_pkg::CMD_BLKCNT, 32'h2, 60);
    wb(1'b0, sdrc_pkg::WB_BLKCNT, 32'h0);
    chk("preset count", 32'h2, q);
    cmd(sdrc_pkg::CMD_RD_MULTI, 32'h0, 24 * len + 120);
    chk("preset blocks", 32'h2, nblk);
    cmd(sdrc_pkg::CMD_RD_MULTI, 32'h0, 24 * len + 120);
    chk("stream blocks", 32'h1, nblk >= 3);
    cmd(sdrc_pkg::CMD_STOP, 32'h0, 8 * len + 100);
    chk("stop index", sdrc_pkg::CMD_STOP, resp[45:40]);
    cmd(sdrc_pkg::CMD_STATUS, {RCA, 16'h0000}, 8 * len + 60);
    chk("quiet after stop", 32'h0, lowcnt);
    done("multi read");
    // partial reads allowed, so a programmed length leaking in would show
    ctl(4'b0101);
    len = 32'h200;
    cmd(sdrc_pkg::CMD_RD_ONE, 32'h3, 4200);
    chk("wide blocks", 32'h1, nblk);
    chk("block unit byte", 32'h06, fb);
    done("high capacity");
    len = 32'd64;
    cmd(sdrc_pkg::CMD_TUNE, 32'h0, 620);
    chk("tune blocks", 32'h1, nblk);
    chk("tune first byte", 32'h0, fb);
    adr = rnd();
    cmd(sdrc_pkg::CMD_SPEED, adr, 90);
    chk("speed busy", 32'd9, lowcnt);
    wb(1'b0, sdrc_pkg::WB_SPEED, 32'h0);
    chk("speed arg", adr, q);
    for (int k = 0; k < 2; k++) begin
      cmd(k ? sdrc_pkg::CMD_RSV_B : sdrc_pkg::CMD_RSV_A, 32'h0, 60);
      chk("reserved silent", 32'h0, rcnt);
      wb(1'b0, sdrc_pkg::WB_STATUS, 32'h0);
      chk("illegal status bit", 32'h1, q[sdrc_pkg::ST_ILLEGAL]);
      cmd(sdrc_pkg::CMD_STATUS, {RCA, 16'h0000}, 60);
      chk("illegal flag", 32'h1, resp[30]);
    end
    done("tune speed reserved");
    cmd(sdrc_pkg::CMD_INACT, {~RCA, 16'h0000}, 60);
    wb(1'b0, sdrc_pkg::WB_STATE, 32'h0);
    chk("foreign inactive", 32'h0, q[0]);
    cmd(sdrc_pkg::CMD_INACT, {RCA, 16'h0000}, 60);
    chk("inactive silent", 32'h0, rcnt);
    wb(1'b0, sdrc_pkg::WB_STATE, 32'h0);
    chk("inactive state", 32'h1, q[0]);
    cmd(sdrc_pkg::CMD_STATUS, {RCA, 16'h0000}, 60);
    chk("inactive ignores", 32'h0, rcnt);
    done("inactive");
    tally_and_finish();
  end
endmodule
